// ---- lbcs_defs.svh ----
`ifndef LBCS_DEFS_SVH
`define LBCS_DEFS_SVH

// Timing base
`define LBCS_CLK_HZ       25000000
`define LBCS_CLK_NS       40
`define LBCS_OSC_HZ       1200000
`define LBCS_OSC_PER_100K 12
`define LBCS_SS_STEPS     8
`define LBCS_SS_STEP_NS   213000
`define LBCS_EN_OFF_NS    1000000
`define LBCS_OL_NS        1500
`define LBCS_MIN_ON_NS    65
`define LBCS_DMAX_PCT     93
`define LBCS_TICK_ROUND   9999
`define LBCS_TICK_DIV     10000

// Register byte addresses
`define LBCS_ADDR_CTRL    5'h00
`define LBCS_ADDR_STATUS  5'h04
`define LBCS_ADDR_INT_ST  5'h08
`define LBCS_ADDR_INT_CLR 5'h0c
`define LBCS_ADDR_INT_EN  5'h10

// Field layout
`define LBCS_CTRL_RUN     0
`define LBCS_CTRL_RESET   1'h1
`define LBCS_ST_STATE_LO  0
`define LBCS_ST_STEP_LO   2
`define LBCS_ST_OVP       5
`define LBCS_ST_THERM     6
`define LBCS_ST_GATE      7
`define LBCS_ST_ISO       8
`define LBCS_EV_W         6
`define LBCS_EV_SS_DONE   0
`define LBCS_EV_OL        1
`define LBCS_EV_OVP       2
`define LBCS_EV_THERM     3
`define LBCS_EV_LOCKOUT   4
`define LBCS_EV_SHUTDOWN  5

// Synchronised input positions
`define LBCS_IN_W         9
`define LBCS_IN_EN        0
`define LBCS_IN_DIM       1
`define LBCS_IN_PEAK      2
`define LBCS_IN_LOCK      3
`define LBCS_IN_OL        4
`define LBCS_IN_OVP       5
`define LBCS_IN_OVP_REL   6
`define LBCS_IN_THERM     7
`define LBCS_IN_THERM_OK  8

`endif

// ---- lbcs_pkg.sv ----
package lbcs_pkg;

	typedef enum logic [1:0] {
		LBCS_SHUTDOWN = 2'b00,
		LBCS_SOFT     = 2'b01,
		LBCS_RUN      = 2'b10,
		LBCS_LATCHED  = 2'b11
	} lbcs_state_t;

endpackage

// ---- lbcs_sequencer.sv ----
// Overview of operation
// - Power switch turns on at the start of every fixed 1.2 MHz cycle.
// - Peak current comparator ends the on time; switch stays off until next cycle.
// - Isolation switch follows the dimming input within one microsecond.
// - Isolation switch stays open while dimming input is low.
// - Enable high starts isolation switch and power switching.
// - Current limit ramps to full in eight steps of 213 us each.
// - Enable low for 1 ms stops switching, opens isolation, enters shutdown.
// - Supply lockout keeps both switches off.
// - Overload held 1.5 us latches off until fault gone and enable toggled.
// - Overload detector ignored until the soft-start ramp completes.
// - Overvoltage stops power switch and opens isolation in the same cycle.
// - After overvoltage, switching resumes only once output falls 0.6 V lower.
// - Over-temperature turns both switches off until temperature falls by hysteresis.
// - Each power switch on pulse lasts at least 65 ns unless a fault cuts it short.
`timescale 1ns/100ps
`include "lbcs_defs.svh"

module lbcs_sequencer
	import lbcs_pkg::*;
#(
	parameter int unsigned SS_STEP_TICKS =
		(`LBCS_SS_STEP_NS * `LBCS_OSC_PER_100K + `LBCS_TICK_ROUND) / `LBCS_TICK_DIV,
	parameter int unsigned EN_OFF_TICKS =
		(`LBCS_EN_OFF_NS * `LBCS_OSC_PER_100K + `LBCS_TICK_ROUND) / `LBCS_TICK_DIV,
	parameter int unsigned OL_TICKS =
		(`LBCS_OL_NS * `LBCS_OSC_PER_100K + `LBCS_TICK_ROUND) / `LBCS_TICK_DIV
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        EN,
	input  wire logic        DIM,
	input  wire logic        PEAK_CMP,
	input  wire logic        SUPPLY_LOCKOUT,
	input  wire logic        OVERLOAD_TRIP,
	input  wire logic        OVP_TRIP,
	input  wire logic        OVP_RELEASE,
	input  wire logic        THERM_TRIP,
	input  wire logic        THERM_OK,
	output logic             GATE,
	output logic             ISO,
	output logic [2:0]       ILIM_STEP,
	output logic             IRQ,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [31:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O
);

	localparam int unsigned OSC_DIV  = `LBCS_CLK_HZ / `LBCS_OSC_HZ;
	localparam int unsigned DMAX_CYC = OSC_DIV * `LBCS_DMAX_PCT / 100;
	localparam int unsigned MIN_ON   = (`LBCS_MIN_ON_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS;
	localparam int unsigned LAST_STEP = `LBCS_SS_STEPS - 1;

	// Input synchronisers
	// Only the second stage feeds logic, so a metastable first stage never spreads
	logic [`LBCS_IN_W-1:0] sync_a;
	logic [`LBCS_IN_W-1:0] sync_b;
	wire  [`LBCS_IN_W-1:0] raw_in = {THERM_OK, THERM_TRIP, OVP_RELEASE, OVP_TRIP,
		OVERLOAD_TRIP, SUPPLY_LOCKOUT, PEAK_CMP, DIM, EN};

	genvar gi;
	generate
		for (gi = 0; gi < `LBCS_IN_W; gi++) begin : g_sync
			always_ff @(posedge CLK) begin
				if (RST) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire en_s       = sync_b[`LBCS_IN_EN];
	wire dim_s      = sync_b[`LBCS_IN_DIM];
	wire peak_s     = sync_b[`LBCS_IN_PEAK];
	wire lock_s     = sync_b[`LBCS_IN_LOCK];
	wire ol_s       = sync_b[`LBCS_IN_OL];
	wire ovp_s      = sync_b[`LBCS_IN_OVP];
	wire ovp_rel_s  = sync_b[`LBCS_IN_OVP_REL];
	wire therm_s    = sync_b[`LBCS_IN_THERM];
	wire therm_ok_s = sync_b[`LBCS_IN_THERM_OK];

	// Oscillator: one-cycle tick at the start of each switching period
	logic [4:0] osc_cnt;
	wire        osc_tick = (osc_cnt == 5'(OSC_DIV - 1));

	always_ff @(posedge CLK) begin
		if (RST)
			osc_cnt <= 5'h00;
		else
			osc_cnt <= osc_tick ? 5'h00 : osc_cnt + 5'h01;
	end

	// Software control and fault holds
	logic        ctrl_run;
	logic        ovp_hold;
	logic        therm_hold;
	lbcs_state_t state;
	lbcs_state_t next_state;
	logic [2:0]  step;
	logic [11:0] step_cnt;
	logic [11:0] en_low_cnt;
	logic [11:0] ol_cnt;
	logic        en_seen_low;
	logic [4:0]  on_cnt;

	// Hysteresis: hold until the release comparator reports the lower level
	always_ff @(posedge CLK) begin
		if (RST) begin
			ovp_hold   <= 1'b0;
			therm_hold <= 1'b0;
		end else begin
			ovp_hold   <= ovp_s | (ovp_hold & ~ovp_rel_s);
			therm_hold <= therm_s | (therm_hold & ~therm_ok_s);
		end
	end

	wire block    = lock_s | ovp_s | ovp_hold | therm_s | therm_hold;
	wire ss_last  = (step == 3'(LAST_STEP)) && (step_cnt == 12'(SS_STEP_TICKS - 1));
	wire en_off   = !en_s && (en_low_cnt == 12'(EN_OFF_TICKS - 1)) && osc_tick;
	wire ol_fire  = (state == LBCS_RUN) && ol_s && osc_tick
		&& (ol_cnt == 12'(OL_TICKS - 1));
	wire start_ok = en_s && ctrl_run && !lock_s;

	always_comb begin
		next_state = state;
		case (state)
			LBCS_SHUTDOWN: begin
				if (start_ok)
					next_state = LBCS_SOFT;
			end
			LBCS_SOFT: begin
				if (lock_s || en_off || !ctrl_run)
					next_state = LBCS_SHUTDOWN;
				else if (osc_tick && ss_last)
					next_state = LBCS_RUN;
			end
			LBCS_RUN: begin
				if (lock_s || en_off || !ctrl_run)
					next_state = LBCS_SHUTDOWN;
				else if (ol_fire)
					next_state = LBCS_LATCHED;
			end
			LBCS_LATCHED: begin
				// Only a low then high enable with the overload gone unlatches
				if (en_seen_low && en_s && !ol_s)
					next_state = LBCS_SHUTDOWN;
			end
			default: next_state = LBCS_SHUTDOWN;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST)
			state <= LBCS_SHUTDOWN;
		else
			state <= next_state;
	end

	// Soft-start ramp, counted in oscillator ticks
	always_ff @(posedge CLK) begin
		if (RST) begin
			step     <= 3'h0;
			step_cnt <= 12'h000;
		end else if (state != LBCS_SOFT) begin
			// Run keeps the full limit; every other state restarts the ramp
			step     <= (state == LBCS_RUN) ? 3'(LAST_STEP) : 3'h0;
			step_cnt <= 12'h000;
		end else if (osc_tick) begin
			if (step_cnt == 12'(SS_STEP_TICKS - 1)) begin
				step_cnt <= 12'h000;
				if (step != 3'(LAST_STEP))
					step <= step + 3'h1;
			end else begin
				step_cnt <= step_cnt + 12'h001;
			end
		end
	end

	// Enable-low timer and overload deglitch
	always_ff @(posedge CLK) begin
		if (RST || en_s)
			en_low_cnt <= 12'h000;
		else if (osc_tick && en_low_cnt != 12'(EN_OFF_TICKS - 1))
			en_low_cnt <= en_low_cnt + 12'h001;
	end

	always_ff @(posedge CLK) begin
		if (RST || !ol_s || state != LBCS_RUN)
			ol_cnt <= 12'h000;
		else if (osc_tick && ol_cnt != 12'(OL_TICKS - 1))
			ol_cnt <= ol_cnt + 12'h001;
	end

	always_ff @(posedge CLK) begin
		if (RST || state != LBCS_LATCHED)
			en_seen_low <= 1'b0;
		else if (!en_s)
			en_seen_low <= 1'b1;
	end

	// Power switch gate: on at tick, off at peak after the minimum width
	// A fault cuts an on pulse short: protection outranks the minimum width
	wire gate_ok   = (next_state == LBCS_SOFT || next_state == LBCS_RUN) && !block;
	wire min_done  = on_cnt >= 5'(MIN_ON);
	wire dmax_end  = osc_cnt == 5'(DMAX_CYC - 1);
	wire next_gate = !gate_ok ? 1'b0 :
		osc_tick ? 1'b1 :
		(GATE && ((peak_s && min_done) || dmax_end)) ? 1'b0 :
		GATE;
	wire next_iso  = gate_ok && dim_s;

	always_ff @(posedge CLK) begin
		if (RST) begin
			GATE   <= 1'b0;
			ISO    <= 1'b0;
			on_cnt <= 5'h00;
		end else begin
			GATE   <= next_gate;
			ISO    <= next_iso;
			on_cnt <= next_gate ? on_cnt + 5'h01 : 5'h00;
		end
	end

	assign ILIM_STEP = step;

	// Events and interrupt
	logic [`LBCS_EV_W-1:0] int_st;
	logic [`LBCS_EV_W-1:0] int_en;
	logic                  sync_b_lock_q;
	wire  [`LBCS_EV_W-1:0] events = {
		(state != LBCS_SHUTDOWN) && (next_state == LBCS_SHUTDOWN),
		lock_s && !sync_b_lock_q,
		therm_s && !therm_hold,
		ovp_s && !ovp_hold,
		ol_fire,
		(state == LBCS_SOFT) && (next_state == LBCS_RUN)};

	always_ff @(posedge CLK) begin
		if (RST)
			sync_b_lock_q <= 1'b0;
		else
			sync_b_lock_q <= lock_s;
	end

	// Wishbone slave, one wait state
	wire        wb_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire [4:0]  wb_addr  = {WB_ADR_I[4:2], 2'b00};
	wire        wr_lane  = wb_req && WB_WE_I && WB_SEL_I[0];
	wire        wr_ctrl  = wr_lane && (wb_addr == `LBCS_ADDR_CTRL);
	wire        wr_clr   = wr_lane && (wb_addr == `LBCS_ADDR_INT_CLR);
	wire        wr_en    = wr_lane && (wb_addr == `LBCS_ADDR_INT_EN);
	wire [`LBCS_EV_W-1:0] clr_mask = wr_clr ? WB_DAT_I[`LBCS_EV_W-1:0] : '0;
	wire [31:0] status_w = 32'({ISO, GATE, therm_hold, ovp_hold, step, state});
	wire [31:0] rd_mux   =
		(wb_addr == `LBCS_ADDR_CTRL)   ? 32'(ctrl_run) :
		(wb_addr == `LBCS_ADDR_STATUS) ? status_w :
		(wb_addr == `LBCS_ADDR_INT_ST) ? 32'(int_st) :
		(wb_addr == `LBCS_ADDR_INT_EN) ? 32'(int_en) : 32'h0000_0000;

	always_ff @(posedge CLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= (wb_req && !WB_WE_I) ? rd_mux : 32'h0000_0000;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_run <= `LBCS_CTRL_RESET;
			int_en   <= '0;
			int_st   <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_run <= WB_DAT_I[`LBCS_CTRL_RUN];
			if (wr_en)
				int_en <= WB_DAT_I[`LBCS_EV_W-1:0];
			int_st <= (int_st & ~clr_mask) | events;
		end
	end

	assign IRQ = |(int_st & int_en);

	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	a_lockout_off: assert property (lock_s |=> !GATE && !ISO)
		else $error("Switch on during supply lockout");
	a_ovp_same_cycle: assert property ($rose(ovp_s) |=> !GATE && !ISO)
		else $error("Overvoltage did not drop both switches together");
	a_ovp_hyst: assert property (ovp_hold && !ovp_rel_s && !ovp_s |=> !GATE)
		else $error("Switching resumed before overvoltage release");
	a_therm_off: assert property (therm_s ##1 (therm_hold && !therm_ok_s) |=> !ISO)
		else $error("Isolation on during thermal hold");
	a_dim_follow: assert property (gate_ok && dim_s |=> ISO)
		else $error("Isolation did not follow dimming high");
	a_dim_open: assert property (!dim_s |=> !ISO)
		else $error("Isolation closed while dimming low");
	a_cycle_start: assert property (osc_tick && gate_ok |=> GATE)
		else $error("Switch not on at cycle start");
	a_min_width: assert property ($rose(GATE) && gate_ok |=> GATE)
		else $error("Gate pulse shorter than minimum");
	a_peak_end: assert property (GATE && peak_s && min_done && !osc_tick |=> !GATE)
		else $error("Peak comparator did not end on time");
	a_ol_masked: assert property (state == LBCS_SOFT |=> state != LBCS_LATCHED)
		else $error("Overload acted during soft start");
	a_latch_stays: assert property (state == LBCS_LATCHED && !en_seen_low |=>
		state == LBCS_LATCHED)
		else $error("Overload latch released without enable toggle");
	a_en_shutdown: assert property (en_off && state != LBCS_LATCHED |=>
		state == LBCS_SHUTDOWN ##1 (!GATE && !ISO))
		else $error("Enable low timeout did not shut down");
	a_ramp_done: assert property (state == LBCS_SOFT ##1 state == LBCS_RUN |->
		$past(step) == 3'(LAST_STEP))
		else $error("Ramp ended before final step");
	a_start: assert property (state == LBCS_SHUTDOWN && start_ok |=>
		state == LBCS_SOFT)
		else $error("Enable high did not start");

	c_soft_done: cover property (state == LBCS_SOFT ##1 state == LBCS_RUN);
	c_ol_latch: cover property (state == LBCS_RUN ##1 state == LBCS_LATCHED);
	c_ovp_trip: cover property ($rose(ovp_hold) ##[1:400] $fell(ovp_hold));
	c_dim_pulse: cover property ($rose(ISO) ##[1:200] $fell(ISO));
	c_shut_entry: cover property (state != LBCS_SHUTDOWN ##1 state == LBCS_SHUTDOWN);

endmodule

// ---- lbcs_host.sv ----
`timescale 1ns/100ps
module lbcs_host (
	input  wire logic clk,
	output logic      en,
	output logic      dim
);
	logic prev = 1'b0;
	int   on_n = 0;
	int   per_n = 1000;
	initial begin
		en = 1'b0;
		dim = 1'b0;
	end
	always @(posedge clk) begin
		prev <= dim;
		on_n <= dim ? on_n + 1 : 0;
		per_n <= (dim && !prev) ? 1 : per_n + 1;
	end
	task automatic set_en(input logic v);
		@(posedge clk);
		en <= v;
	endtask
	// Edges are held back so no dimming pulse beats the host limits
	task automatic set_dim(input logic v);
		@(posedge clk);
		while (v && per_n < 625) @(posedge clk);
		while (!v && dim && on_n < 250) @(posedge clk);
		dim <= v;
	endtask
endmodule

// ---- test_lbcs_sequencer.sv ----
`timescale 1ns/100ps
`include "lbcs_defs.svh"
module test_lbcs_sequencer;
	localparam int TK = 20;
	logic        clk = 1'b0;
	logic        rst;
	logic        peak;
	logic        lock;
	logic        ol;
	logic        ovp;
	logic        ovr;
	logic        th;
	logic        tok;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [31:0] adr;
	logic [31:0] di;
	logic [3:0]  sel;
	logic [3:0]  wsel;
	logic [31:0] rd;
	logic        en;
	logic        dim;
	logic        gate;
	logic        iso;
	logic        irq;
	logic        ack;
	logic [2:0]  step;
	logic [31:0] dq;
	wire  [3:0]  obs;
	int          n_fail = 0;
	int          comparisons = 0;
	assign obs = {step == 3'h7, irq, iso, gate};
	lbcs_sequencer #(.SS_STEP_TICKS(4), .EN_OFF_TICKS(8), .OL_TICKS(2)) u_dut (
		.CLK(clk), .RST(rst), .EN(en), .DIM(dim), .PEAK_CMP(peak),
		.SUPPLY_LOCKOUT(lock), .OVERLOAD_TRIP(ol), .OVP_TRIP(ovp),
		.OVP_RELEASE(ovr), .THERM_TRIP(th), .THERM_OK(tok), .GATE(gate),
		.ISO(iso), .ILIM_STEP(step), .IRQ(irq), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(di), .WB_SEL_I(sel),
		.WB_DAT_O(dq), .WB_ACK_O(ack));
	lbcs_host u_host (.clk(clk), .en(en), .dim(dim));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic timeout(input string m);
		n_fail++;
		$display("MISMATCH %0t timeout %s", $time, m);
		results();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// Samples settle before the edge, so flags read here are pre-edge values
	task automatic wait_on(input int b, input logic v, input int lim, output int n);
		n = 0;
		comparisons++;
		while (obs[b] !== v) begin
			@(posedge clk);
			n++;
			if (n > lim) timeout($sformatf("on bit %0d", b));
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {27'h0, a};
		di <= d;
		sel <= wsel;
		i = 0;
		do begin
			@(posedge clk);
			i++;
			if (i > 50) timeout("bus ack");
		end while (ack !== 1'b1);
		chk(ack, 1'b1, "bus ack");
		rd = dq;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic t_reset();
		chk({gate, iso, step, irq}, 6'h0, "reset outputs");
		wb(1'b0, `LBCS_ADDR_CTRL, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		wsel = 4'he;
		wb(1'b1, `LBCS_ADDR_CTRL, 32'h0);
		wsel = 4'hf;
		wb(1'b0, `LBCS_ADDR_CTRL, 32'h0);
		chk(rd, 32'h1, "write without lane 0 ignored");
		wb(1'b1, 5'h14, 32'hffff);
		wb(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0, "unmapped");
		wb(1'b0, `LBCS_ADDR_INT_EN, 32'h0);
		chk(rd, 32'h0, "int_en reset");
		$display("reset test done");
	endtask
	task automatic t_start();
		int n;
		int k;
		logic [2:0] s;
		u_host.set_dim(1'b1);
		ol <= 1'b1;
		u_host.set_en(1'b1);
		wait_on(1, 1'b1, 25, n);
		wait_on(0, 1'b1, 40, n);
		for (k = 0; k < 7; k++) begin
			s = step;
			n = 0;
			while (step === s) begin
				@(posedge clk);
				n++;
				if (n > 200) timeout("ramp step");
			end
			if (k == 5) ol <= 1'b0;
			if (k > 0) chk(n, 4 * TK, "step length");
		end
		chk(step, 3'h7, "full limit");
		repeat (100) @(posedge clk);
		chk(iso, 1'b1, "overload during ramp");
		$display("start test done");
	endtask
	task automatic t_peak();
		int n;
		int m;
		wait_on(0, 1'b0, 30, n);
		wait_on(0, 1'b1, 30, n);
		wait_on(0, 1'b0, 30, n);
		wait_on(0, 1'b1, 30, m);
		chk(n + m, TK, "switch period");
		peak <= 1'b1;
		wait_on(0, 1'b0, 30, n);
		wait_on(0, 1'b1, 30, n);
		wait_on(0, 1'b0, 10, n);
		chk(n >= 2 && n <= 6, 1'b1, "on width");
		wait_on(0, 1'b1, 30, m);
		chk(n + m, TK, "off until next cycle");
		peak <= 1'b0;
		$display("peak test done");
	endtask
	task automatic t_dim();
		int n;
		int bad;
		u_host.set_dim(1'b0);
		wait_on(1, 1'b0, 25, n);
		bad = 0;
		repeat (300) begin
			@(posedge clk);
			if (iso !== 1'b0) bad++;
		end
		chk(bad, 0, "iso held open");
		u_host.set_dim(1'b1);
		wait_on(1, 1'b1, 25, n);
		$display("dim test done");
	endtask
	// Overvoltage and over-temperature share one sequence
	task automatic t_prot(input int k);
		int n;
		int bad;
		ovp <= (k == 0);
		th <= (k == 1);
		wait_on(1, 1'b0, 10, n);
		chk(gate, 1'b0, "both switches off");
		ovp <= 1'b0;
		th <= 1'b0;
		bad = 0;
		repeat (200) begin
			@(posedge clk);
			if (gate !== 1'b0 || iso !== 1'b0) bad++;
		end
		chk(bad, 0, "held off in hysteresis");
		ovr <= (k == 0);
		tok <= (k == 1);
		wait_on(0, 1'b1, 60, n);
		wait_on(1, 1'b1, 60, n);
		ovr <= 1'b0;
		tok <= 1'b0;
		$display("protection test %0d done", k);
	endtask
	task automatic t_lock();
		int n;
		int bad;
		lock <= 1'b1;
		wait_on(1, 1'b0, 10, n);
		bad = 0;
		repeat (200) begin
			@(posedge clk);
			if (gate !== 1'b0 || iso !== 1'b0) bad++;
		end
		chk(bad, 0, "lockout off");
		lock <= 1'b0;
		wait_on(3, 1'b1, 800, n);
		$display("lockout test done");
	endtask
	task automatic t_ovl();
		int n;
		int bad;
		// Let the ramp finish so the short pulse is judged in run, not masked
		repeat (100) @(posedge clk);
		ol <= 1'b1;
		repeat (10) @(posedge clk);
		ol <= 1'b0;
		repeat (60) @(posedge clk);
		chk(iso, 1'b1, "short overload ignored");
		ol <= 1'b1;
		wait_on(1, 1'b0, 70, n);
		ol <= 1'b0;
		bad = 0;
		repeat (200) begin
			@(posedge clk);
			if (gate !== 1'b0 || iso !== 1'b0) bad++;
		end
		chk(bad, 0, "stays latched");
		u_host.set_en(1'b0);
		repeat (60) @(posedge clk);
		u_host.set_en(1'b1);
		wait_on(0, 1'b1, 100, n);
		wait_on(3, 1'b1, 800, n);
		$display("overload test done");
	endtask
	task automatic t_irq();
		wb(1'b0, `LBCS_ADDR_INT_ST, 32'h0);
		chk(rd & 32'h1f, 32'h1f, "events seen");
		chk(irq, 1'b0, "masked");
		wb(1'b1, `LBCS_ADDR_INT_EN, 32'h4);
		@(posedge clk);
		chk(irq, 1'b1, "irq raised");
		wb(1'b1, `LBCS_ADDR_INT_CLR, 32'h4);
		@(posedge clk);
		chk(irq, 1'b0, "irq cleared");
		wb(1'b0, `LBCS_ADDR_INT_ST, 32'h0);
		chk(rd & 32'h4, 32'h0, "bit cleared");
		$display("irq test done");
	endtask
	task automatic t_shut();
		int n;
		u_host.set_en(1'b0);
		wait_on(1, 1'b0, 300, n);
		chk(n >= 7 * TK && n <= 9 * TK + 5, 1'b1, "enable low delay");
		repeat (60) @(posedge clk);
		chk(gate, 1'b0, "no switching");
		wb(1'b0, `LBCS_ADDR_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h0, "shutdown state");
		$display("shutdown test done");
	endtask
	initial begin
		rst = 1'b1;
		{peak, lock, ol, ovp, ovr, th, tok} = 7'h00;
		{cyc, stb, we} = 3'h0;
		adr = 32'h0000_0000;
		di = 32'h0000_0000;
		sel = 4'h0;
		wsel = 4'hf;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_start();
		t_peak();
		t_dim();
		t_prot(0);
		t_prot(1);
		t_lock();
		t_ovl();
		t_irq();
		t_shut();
		results();
	end
endmodule
